// *** rtl/tts_pkg.sv ***
package tts_pkg;
    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 8;
    localparam int NUM_EVT     = 8;   // events a..h
    localparam int NUM_QUAL    = 2;   // qualifiers per condition
    localparam int NUM_STATE   = 6;
    localparam int LOOP_W      = 16;
    localparam int CYC_W       = 32;
    localparam int LOOP_BIT    = 3;   // loop counter condition bit
    localparam int CCEN_BIT    = 5;   // cycle count enable bit
    // ---------------------------------------------------------------
    // cycle types, one-hot
    // ---------------------------------------------------------------
    localparam logic [2:0] CYC_READ  = 3'h1;
    localparam logic [2:0] CYC_WRITE = 3'h2;
    localparam logic [2:0] CYC_FETCH = 3'h4;
    // ---------------------------------------------------------------
    // reset values and timing
    // ---------------------------------------------------------------
    localparam logic [NUM_STATE-1:0] STATE_RST = 6'h00;
    localparam logic [LOOP_W-1:0]    LOOP_RST  = 16'h0000;
    localparam longint CLK_HZ        = 20000000;
    localparam longint HOLD_DEN      = 5;  // hold is 1/5 second
    localparam longint HOLD_CYC_L    = CLK_HZ / HOLD_DEN;
    localparam logic [23:0] HOLD_CYC = 24'(HOLD_CYC_L);
    // reset-and-go sequencer
    typedef enum logic [2:0] {
        RG_IDLE = 3'b001,
        RG_HOLD = 3'b010,
        RG_RUN  = 3'b100
    } tts_rg_t;
endpackage

// *** rtl/tts_cond.sv ***
`timescale 1ns/10ps
// one condition: fields of its qualifiers merged by or
module tts_cond (
    input  wire logic [15:0] bus_addr,
    input  wire logic [2:0]  bus_type,
    input  wire logic [31:0] q_addr,
    input  wire logic [31:0] q_mask,
    input  wire logic [5:0]  q_type,
    input  wire logic        enable,
    output logic             hit
);
    logic addr_any;
    logic type_any;
    // ---------------------------------------------------------------
    // field merge
    // ---------------------------------------------------------------
    // crossed combinations match on purpose: fields are merged, not qualifiers
    always_comb begin
        addr_any = ((bus_addr & q_mask[15:0]) == (q_addr[15:0] & q_mask[15:0]))
                 | ((bus_addr & q_mask[31:16]) == (q_addr[31:16] & q_mask[31:16]));
        type_any = |((q_type[2:0] | q_type[5:3]) & bus_type);
        hit      = enable & addr_any & type_any;
    end
endmodule

// *** rtl/tts_top.sv ***
`timescale 1ns/10ps
module tts_top #(
    parameter logic [23:0] HOLD_CYCLES = tts_pkg::HOLD_CYC
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        bus_strobe,
    input  wire logic [15:0] bus_addr,
    input  wire logic [2:0]  bus_type,
    input  wire logic [255:0] cond_addr,
    input  wire logic [255:0] cond_mask,
    input  wire logic [47:0] cond_type,
    input  wire logic [7:0]  cond_enable,
    input  wire logic [47:0] set_sel,
    input  wire logic [47:0] clr_sel,
    input  wire logic [5:0]  set_state_sel,
    input  wire logic [5:0]  set_state_pol,
    input  wire logic [7:0]  trig_evt_sel,
    input  wire logic [5:0]  trig_state_sel,
    input  wire logic [7:0]  rec_evt_sel,
    input  wire logic [5:0]  rec_state_sel,
    input  wire logic        rec_always,
    input  wire logic [5:0]  count_mode,
    input  wire logic [15:0] loop_preload,
    input  wire logic        loop_load,
    input  wire logic        reset_and_go,
    output logic [5:0]       state_bits,
    output logic [15:0]      loop_count,
    output logic [31:0]      cycle_count,
    output logic             triggered,
    output logic             record_frame,
    output logic             emulating,
    output logic             trace_on,
    output logic             target_reset_n
);
    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [2:0] strb_sync;
    logic       rg_s1, rg_s2, rg_s3;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            strb_sync <= 3'h0;
            rg_s1     <= 1'b0;
            rg_s2     <= 1'b0;
            rg_s3     <= 1'b0;
        end else begin
            strb_sync <= {strb_sync[1:0], bus_strobe};
            rg_s1     <= reset_and_go;
            rg_s2     <= rg_s1;
            rg_s3     <= rg_s2;
        end
    end
    // one step per bus cycle, on the synced rising edge
    logic step;
    logic rg_req;
    assign step   = strb_sync[1] & ~strb_sync[2];
    assign rg_req = rg_s2 & ~rg_s3;
    // ---------------------------------------------------------------
    // event matching
    // ---------------------------------------------------------------
    logic [7:0] evt;
    for (genvar i = 0; i < 8; i++) begin : g_cond
        tts_cond u_cond (
            .bus_addr (bus_addr),
            .bus_type (bus_type),
            .q_addr   (cond_addr[i*32 +: 32]),
            .q_mask   (cond_mask[i*32 +: 32]),
            .q_type   (cond_type[i*6 +: 6]),
            .enable   (cond_enable[i]),
            .hit      (evt[i])
        );
    end
    // ---------------------------------------------------------------
    // state equations
    // ---------------------------------------------------------------
    // each bit: set term = or of selected events, anded with state literals,
    // clear term = or of selected events; count_mode bits 0..2 toggle instead
    logic [5:0] state;
    logic [5:0] next_state;
    logic [5:0] set_t;
    logic [5:0] clr_t;
    logic [5:0] carry;
    always_comb begin
        for (int b = 0; b < 6; b++) begin
            set_t[b] = (|set_sel[b*8 +: 8]) & ((evt & set_sel[b*8 +: 8]) != 8'h00)
                     & (((state ^ set_state_pol) & set_state_sel) == 6'h00);
            clr_t[b] = |(evt & clr_sel[b*8 +: 8]);
        end
        // a counting bit only toggles once every bit below it is set
        carry      = {3'h7, state[1] & state[0], state[0], 1'b1};
        next_state = state;
        if (step) begin
            for (int b = 0; b < 6; b++) begin
                if (count_mode[b] && b < 3) begin
                    // toggle written as and/or/not: b xor (lower bits and event)
                    next_state[b] = (state[b] & ~(set_t[b] & carry[b]))
                                  | (~state[b] & set_t[b] & carry[b]);
                end else if (set_t[b]) begin
                    next_state[b] = 1'b1;
                end else if (clr_t[b]) begin
                    next_state[b] = 1'b0;
                end
            end
        end
    end
    // ---------------------------------------------------------------
    // trigger and record
    // ---------------------------------------------------------------
    logic trig_now;
    logic rec_now;
    logic next_triggered;
    // whole condition results are ored; state literals anded for the trigger, ored for the record
    always_comb begin
        trig_now = ((trig_evt_sel == 8'h00) | (|(evt & trig_evt_sel)))
                 & ((state & trig_state_sel) == trig_state_sel)
                 & ((trig_evt_sel != 8'h00) | (trig_state_sel != 6'h00));
        // set event itself in the expression catches the first frame
        rec_now  = rec_always | (|(evt & rec_evt_sel))
                 | (|(state & rec_state_sel));
        next_triggered = ~rg_req & (triggered | (step & trace_on & trig_now));
    end
    assign record_frame = step & trace_on & rec_now;
    // ---------------------------------------------------------------
    // loop and cycle counters
    // ---------------------------------------------------------------
    logic        loop_prev;
    logic        next_loop_prev;
    logic [15:0] next_loop;
    logic [31:0] next_cycle;
    always_comb begin
        next_loop_prev = loop_prev;
        next_loop      = loop_count;
        next_cycle     = cycle_count;
        if (loop_load) begin
            next_loop = loop_preload;
        end else if (step) begin
            next_loop_prev = state[tts_pkg::LOOP_BIT];
            if (state[tts_pkg::LOOP_BIT] && !loop_prev && loop_count != 16'h0000) begin
                next_loop = loop_count - 16'h0001;
            end
        end
        if (step && trace_on && state[tts_pkg::CCEN_BIT]) begin
            next_cycle = cycle_count + 32'h0000_0001;
        end
        // a new reset-and-go starts the count afresh
        if (rg_req) begin
            next_cycle = 32'h0000_0000;
        end
    end
    // ---------------------------------------------------------------
    // reset-and-go sequencer
    // ---------------------------------------------------------------
    tts_pkg::tts_rg_t rg;
    tts_pkg::tts_rg_t next_rg;
    logic [23:0]      hold_cnt;
    logic [23:0]      next_hold;
    always_comb begin
        next_rg   = rg;
        next_hold = hold_cnt;
        case (rg)
            tts_pkg::RG_IDLE: begin
                if (rg_req) begin
                    next_rg   = tts_pkg::RG_HOLD;
                    next_hold = HOLD_CYCLES - 24'h000001;
                end
            end
            tts_pkg::RG_HOLD: begin
                if (hold_cnt == 24'h000000) begin
                    next_rg = tts_pkg::RG_RUN;
                end else begin
                    next_hold = hold_cnt - 24'h000001;
                end
            end
            tts_pkg::RG_RUN: begin
                if (rg_req) begin
                    next_rg   = tts_pkg::RG_HOLD;
                    next_hold = HOLD_CYCLES - 24'h000001;
                end
            end
            default: next_rg = tts_pkg::RG_IDLE;
        endcase
    end
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state       <= tts_pkg::STATE_RST;
            triggered   <= 1'b0;
            loop_prev   <= 1'b0;
            loop_count  <= tts_pkg::LOOP_RST;
            cycle_count <= 32'h0000_0000;
            rg          <= tts_pkg::RG_IDLE;
            hold_cnt    <= 24'h000000;
        end else begin
            state       <= next_state;
            triggered   <= next_triggered;
            loop_prev   <= next_loop_prev;
            loop_count  <= next_loop;
            cycle_count <= next_cycle;
            rg          <= next_rg;
            hold_cnt    <= next_hold;
        end
    end
    // all three outputs switch off the one state register: same cycle
    assign emulating      = (rg != tts_pkg::RG_IDLE);
    assign trace_on       = (rg != tts_pkg::RG_IDLE);
    assign target_reset_n = (rg != tts_pkg::RG_HOLD);
    assign state_bits     = state;
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_hold_start;
        $rose(rg == tts_pkg::RG_HOLD);
    endsequence
    chk_rg_together: assert property (@(posedge clock) disable iff (!reset_n)
        s_hold_start |-> (!target_reset_n && trace_on && emulating))
        else $error("reset-and-go outputs not together");
    chk_hold_stays: assert property (@(posedge clock) disable iff (!reset_n)
        (rg == tts_pkg::RG_HOLD && hold_cnt != 24'h000000) |=> !target_reset_n)
        else $error("target reset released early");
    chk_hold_ends: assert property (@(posedge clock) disable iff (!reset_n)
        (rg == tts_pkg::RG_HOLD && hold_cnt == 24'h000000) |=> target_reset_n)
        else $error("target reset not released");
    chk_set_holds: assert property (@(posedge clock) disable iff (!reset_n)
        (step && set_t[4] && !count_mode[4]) |=> state[4])
        else $error("set term did not set bit");
    chk_bit_sticky: assert property (@(posedge clock) disable iff (!reset_n)
        (state[4] && !(step && clr_t[4])) |=> state[4])
        else $error("set bit dropped without clear");
    chk_loop_edge: assert property (@(posedge clock) disable iff (!reset_n)
        (step && !loop_load && state[3] && loop_prev) |=> $stable(loop_count))
        else $error("loop counter moved without rising edge");
    chk_loop_dec: assert property (@(posedge clock) disable iff (!reset_n)
        (step && !loop_load && state[3] && !loop_prev && loop_count != 16'h0000)
        |=> (loop_count == $past(loop_count) - 16'h0001))
        else $error("loop counter missed decrement");
    chk_rec_reset: assert property (@(posedge clock) disable iff (!reset_n)
        (step && !target_reset_n && rec_now) |-> record_frame)
        else $error("frame lost during target reset");
    chk_trig_fire: assert property (@(posedge clock) disable iff (!reset_n)
        (step && trace_on && trig_now && !rg_req) |=> triggered)
        else $error("trigger not taken");
    chk_count_tog: assert property (@(posedge clock) disable iff (!reset_n)
        (step && count_mode[0] && set_t[0]) |=> (state[0] != $past(state[0])))
        else $error("counter bit failed to toggle");
endmodule

// *** dv/tts_target.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// far-side target bus, one strobe per requested bus cycle
// ---------------------------------------------------------------
module tts_target #(
    parameter logic [15:0] VECTOR = 16'hf000  // arbitrary boot address
) (
    input  wire logic        clock,
    input  wire logic        target_reset_n,
    output logic             bus_strobe,
    output logic [15:0]      bus_addr,
    output logic [2:0]       bus_type
);
    initial begin
        bus_strobe = 1'b0;
        bus_addr   = 16'h0000;
        bus_type   = 3'h0;
    end
    // lines hold until the step; afterwards scrambled so stale values never match
    task automatic cycle(input logic [15:0] a, input logic [2:0] t);
        @(posedge clock);
        bus_addr   <= target_reset_n ? a : 16'hfffe;  // held in reset it only reads the vector
        bus_type   <= t;
        bus_strobe <= 1'b1;
        repeat (3) @(posedge clock);
        bus_strobe <= 1'b0;
        repeat (3) @(posedge clock);
        bus_addr   <= ~a;
        bus_type   <= ~t;
    endtask
    // after release: vector bytes, then a fetch at the routine it points to
    task automatic boot();
        cycle(16'hfffe, tts_pkg::CYC_READ);
        cycle(16'hffff, tts_pkg::CYC_READ);
        cycle(VECTOR, tts_pkg::CYC_FETCH);
    endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb;
    // ---------------------------------------------------------------
    // signals and tables
    // ---------------------------------------------------------------
    localparam logic [23:0] HOLD = 24'h000014;  // short hold keeps the run brief
    localparam logic [2:0]  RD   = tts_pkg::CYC_READ;
    localparam logic [2:0]  WR   = tts_pkg::CYC_WRITE;
    localparam logic [2:0]  FE   = tts_pkg::CYC_FETCH;
    logic         clock, reset_n, bus_strobe, rec_always, loop_load, reset_and_go;
    logic [15:0]  bus_addr, loop_preload, loop_count, a;
    logic [2:0]   bus_type, t;
    logic [255:0] cond_addr, cond_mask;
    logic [47:0]  cond_type, set_sel, clr_sel;
    logic [7:0]   cond_enable, trig_evt_sel, rec_evt_sel;
    logic [5:0]   set_state_sel, set_state_pol, trig_state_sel, rec_state_sel, count_mode;
    logic [5:0]   state_bits;
    logic [31:0]  cycle_count;
    logic         triggered, record_frame, emulating, trace_on, target_reset_n;
    int           miscompares, samples_checked, rec_cnt, low_cnt, seed, k;
    logic [15:0]  wa [6] = '{16'h0100, 16'hf0e2, 16'h2000, 16'h2001, 16'hf138, 16'h0100};
    logic [2:0]   wt [6] = '{FE, FE, RD, WR, FE, FE};
    int           we [6] = '{0, 1, 1, 1, 1, 0};
    logic         ws [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    tts_top #(.HOLD_CYCLES(HOLD)) i_tts_top (
        .clock, .reset_n, .bus_strobe, .bus_addr, .bus_type, .cond_addr, .cond_mask,
        .cond_type, .cond_enable, .set_sel, .clr_sel, .set_state_sel, .set_state_pol,
        .trig_evt_sel, .trig_state_sel, .rec_evt_sel, .rec_state_sel, .rec_always,
        .count_mode, .loop_preload, .loop_load, .reset_and_go, .state_bits, .loop_count,
        .cycle_count, .triggered, .record_frame, .emulating, .trace_on, .target_reset_n
    );
    tts_target i_tts_target (.clock, .target_reset_n, .bus_strobe, .bus_addr, .bus_type);

    always #25 clock = ~clock;
    // count recorded frames and clocks spent with the target held in reset
    always @(posedge clock) begin
        if (record_frame === 1'b1)
            rec_cnt <= rec_cnt + 1;
        if (target_reset_n === 1'b0)
            low_cnt <= low_cnt + 1;
    end
    // ---------------------------------------------------------------
    // tasks and expectations
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // bounded wait on the target reset line, polled away from the edge
    task automatic wait_rst(input logic want);
        for (int n = 0; n < 200 && target_reset_n !== want; n++)
            @(negedge clock);
        if (target_reset_n !== want) begin
            miscompares++;
            $display("BAD %0t target reset wait ran out", $time);
            report_and_stop();
        end
    endtask
    // one bus cycle; a negative count skips the record check
    task automatic bus(input logic [15:0] ad, input logic [2:0] ty, input int exp);
        int r0;
        r0 = rec_cnt;
        i_tts_target.cycle(ad, ty);
        if (exp >= 0)
            chk(32'(rec_cnt - r0), 32'(exp), "record count");
    endtask
    task automatic setc(input int i, input logic [15:0] a0, input logic [2:0] t0,
                        input logic [15:0] a1, input logic [2:0] t1, input logic [15:0] m);
        cond_addr[i*32+:32] = {a1, a0};
        cond_mask[i*32+:32] = {m, m};
        cond_type[i*6+:6]   = {t1, t0};
    endtask
    // merged qualifiers match crossed address and type pairs too
    function automatic logic hit_a(input logic [15:0] ad, input logic [2:0] ty);
        return (ad == 16'h0081 || ad == 16'h0082) && (ty == RD || ty == WR);
    endfunction
    function automatic logic hit_be(input logic [15:0] ad, input logic [2:0] ty);
        return (ad == 16'h0081 && ty == WR) || (ad == 16'h3000 && ty == RD);
    endfunction
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        seed = 99;
        clock = 1'b0;
        reset_n = 1'b0;
        {rec_always, loop_load, reset_and_go, loop_preload, cond_enable} = {3'h0, 16'h0, 8'hff};
        setc(0, 16'h0081, WR, 16'h0082, RD, 16'hffff);
        setc(1, 16'h0081, WR, 16'h0081, WR, 16'hffff);
        setc(2, 16'hf0e2, FE, 16'hf0e2, FE, 16'hffff);
        setc(3, 16'hf138, FE, 16'hf138, FE, 16'hffff);
        setc(4, 16'h3000, RD, 16'h3000, RD, 16'hffff);
        setc(5, 16'h3001, RD, 16'h3001, RD, 16'hffff);
        setc(6, 16'h4000, FE, 16'h4000, FE, 16'hffff);
        setc(7, 16'h0000, 3'h7, 16'h0000, 3'h7, 16'h0000);
        set_sel = 48'h80_04_10_40_40_40;
        clr_sel = 48'h00_08_20_00_00_00;
        {set_state_sel, set_state_pol, count_mode} = {6'h00, 6'h00, 6'h07};
        {trig_evt_sel, trig_state_sel, rec_evt_sel, rec_state_sel} = {8'h0, 6'h07, 8'h0, 6'h0};
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rec_always <= 1'b1;
        reset_and_go <= 1'b1;
        wait_rst(1'b0);
        chk(trace_on, 1, "trace on");
        chk(emulating, 1, "emulating");
        @(posedge clock);
        reset_and_go <= 1'b0;
        bus(16'hfffe, RD, 1);
        bus(16'hfffe, RD, 1);
        chk(cycle_count, 1, "cycles in reset");
        wait_rst(1'b1);
        chk(low_cnt, HOLD, "reset hold");
        i_tts_target.boot();
        // random traffic, first one merged condition, then two whole conditions
        @(posedge clock);
        rec_always <= 1'b0;
        rec_evt_sel <= 8'h01;
        for (k = 0; k < 24; k++) begin
            if (k == 12) begin
                @(posedge clock);
                rec_evt_sel <= 8'h12;
            end
            a = {4'h5, 12'($random(seed))};
            case (2'($random(seed)))
                2'h0: a = 16'h0081;
                2'h1: a = 16'h0082;
                2'h2: a = 16'h3000;
                default: ;
            endcase
            t = 3'(3'h1 << ($unsigned($random(seed)) % 3));
            bus(a, t, (k < 12) ? int'(hit_a(a, t)) : int'(hit_be(a, t)));
        end
        // set-clear window with an excursion outside the range
        @(posedge clock);
        rec_evt_sel <= 8'h04;
        rec_state_sel <= 6'h10;
        for (k = 0; k < 6; k++) begin
            bus(wa[k], wt[k], we[k]);
            chk(state_bits[4], ws[k], "window bit");
        end
        chk(triggered, 0, "early trigger");
        // low three bits count fetches of one address, trigger once all are set
        for (k = 0; k < 7; k++) begin
            bus(16'h4000, FE, -1);
            chk(state_bits[2:0], k + 1, "low bits");
        end
        chk(triggered, 0, "trigger before state seen");
        bus(16'h5000, RD, -1);
        chk(triggered, 1, "trigger");
        bus(16'h4000, FE, -1);
        chk(state_bits[2:0], 0, "counter wrap");
        // loop counter counts rises of its bit, never below zero
        for (k = 0; k < 2; k++) begin
            bus(16'h3001, RD, -1);
            @(posedge clock);
            loop_preload <= (k == 0) ? 16'h000a : 16'h0002;
            loop_load <= 1'b1;
            @(posedge clock);
            loop_load <= 1'b0;
            repeat (3) begin
                bus(16'h3000, RD, -1);
                chk(state_bits[tts_pkg::LOOP_BIT], 1, "loop bit");
                bus(16'h3001, RD, -1);
            end
            bus(16'h5000, RD, -1);
            chk(loop_count, (k == 0) ? 7 : 0, "loop count");
        end
        chk(state_bits[tts_pkg::CCEN_BIT], 1, "count enable bit");
        report_and_stop();
    end
endmodule
